/* design/ssfr_top.sv */
// Functional notes
// - Error bit 0 mirrors fatal fault, not cleared on read; bit 1 command failure, cleared on read.
// - Error bit 2 flags configuration fault in normal mode only, cleared on read.
// - Status bit 4 is 0 while a command runs, 1 when ready.
// - Status bit 5 flags new pressure, cleared by any pressure byte read.
// - Status bit 6 flags new temperature, cleared by any temperature byte read.
// - Pressure result bytes low, mid, high at 0x04, 0x05, 0x06.
// - Temperature result bytes low, mid, high at 0x07, 0x08, 0x09.
// - Sensor time bytes low, mid, high at 0x0C, 0x0D, 0x0E.
// - Event bit 0 set after power-up or soft reset, cleared on read.
// - Event bit 1 set by bus access during conversion, cleared on read.
// - Interrupt status: watermark bit 0, full bit 1, data ready bit 3.
// - Queue byte count of 512-byte buffer split over two registers.
// - Reading register 0x14 returns a byte from the queue.
// - Nine-bit threshold: low byte at 0x15, bit 8 at 0x16 bit 0.
// - Frame config bit 0 enables the queue.
// - Frame config bit 1 stops writes when full, else oldest overwritten.
// - Frame config bit 2 returns a time frame once the queue is drained.
// - Frame config bits 3 and 4 store pressure and temperature.
// - Source config bits 2..0 downsample queue input by two to that power.
// - Source config bits 4..3: 1 filtered, other values unfiltered.
// - Irq config bit 0 open-drain, bit 1 active-high pin.
// - Irq config bit 2 latches; bits 3, 4, 6 enable the three sources.
// - Power mode 11 is normal; configuration check runs only there.
`timescale 1ns/1ps
`include "ssfr_cfg.svh"
module ssfr_top (
  input  wire logic                CLK_SYS_I,
  input  wire logic                RST_N_I,
  input  wire logic                CE_I,
  input  wire logic                PSEL_I,
  input  wire logic                PENABLE_I,
  input  wire logic                PWRITE_I,
  input  wire logic [7:0]          PADDR_I,
  input  wire logic [31:0]         PWDATA_I,
  output logic      [31:0]         PRDATA_O,
  output logic                     PREADY_O,
  output logic                     PSLVERR_O,
  input  wire ssfr_pkg::ssfr_sample_t PRESS_RAW_I,
  input  wire ssfr_pkg::ssfr_sample_t PRESS_FILT_I,
  input  wire ssfr_pkg::ssfr_sample_t TEMP_RAW_I,
  input  wire ssfr_pkg::ssfr_sample_t TEMP_FILT_I,
  input  wire logic [23:0]         SENSOR_TIME_I,
  input  wire logic [1:0]          POWER_MODE_I,
  input  wire logic                CMD_BUSY_I,
  input  wire logic                CMD_FAIL_I,
  input  wire logic                CONF_FAULT_I,
  input  wire logic                FATAL_FAULT_I,
  input  wire logic                CONV_ACTIVE_I,
  input  wire logic                SOFT_RESET_I,
  output logic                     INT_O,
  output logic                     INT_OE_N_O,
  output logic                     INT_STRONG_O
);
  import ssfr_pkg::*;

  // Bus decode
  wire       setup = PSEL_I & ~PENABLE_I;
  wire       done  = PSEL_I & PENABLE_I & PREADY_O;
  wire [4:0] idx   = PADDR_I[6:2];
  wire [31:0] map_vec = `SSFR_MAP_MASK;
  wire       hit   = ~PADDR_I[7] & map_vec[idx];
  wire       rd    = done & ~PWRITE_I & hit;
  wire       wr    = done & PWRITE_I & hit;
  wire       rd_err  = rd & (idx == `SSFR_IX_ERR);
  wire       rd_evt  = rd & (idx == `SSFR_IX_EVT);
  wire       rd_ist  = rd & (idx == `SSFR_IX_IST);
  wire       rd_fd   = rd & (idx == `SSFR_IX_FDATA);
  wire       rd_pres = rd & (idx >= `SSFR_IX_P0) & (idx <= `SSFR_IX_P2);
  wire       rd_temp = rd & (idx >= `SSFR_IX_T0) & (idx <= `SSFR_IX_T2);

  // Error, status and event flags
  logic        fatal_reg;
  logic        cmd_err_reg;
  logic        conf_err_reg;
  logic        cmd_rdy_reg;
  logic        drdy_p_reg;
  logic        drdy_t_reg;
  logic        por_reg;
  logic        act_reg;
  logic [23:0] press_reg;
  logic [23:0] temp_reg;
  // Set terms listed last so an event in the clearing cycle survives
  wire cmd_err_next  = (cmd_err_reg & ~rd_err) | CMD_FAIL_I;
  wire conf_err_next = (conf_err_reg & ~rd_err)
                     | (CONF_FAULT_I & (POWER_MODE_I == `SSFR_MODE_NORMAL));
  wire drdy_p_next   = (drdy_p_reg & ~rd_pres) | PRESS_FILT_I.vld;
  wire drdy_t_next   = (drdy_t_reg & ~rd_temp) | TEMP_FILT_I.vld;
  wire por_next      = (por_reg & ~rd_evt) | SOFT_RESET_I;
  wire act_next      = (act_reg & ~rd_evt) | (done & CONV_ACTIVE_I);

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      fatal_reg    <= 1'b0;
      cmd_err_reg  <= 1'b0;
      conf_err_reg <= 1'b0;
      cmd_rdy_reg  <= 1'b1;
      drdy_p_reg   <= 1'b0;
      drdy_t_reg   <= 1'b0;
      por_reg      <= 1'b1;
      act_reg      <= 1'b0;
    end else if (CE_I) begin
      fatal_reg    <= FATAL_FAULT_I;
      cmd_err_reg  <= cmd_err_next;
      conf_err_reg <= conf_err_next;
      cmd_rdy_reg  <= ~CMD_BUSY_I;
      drdy_p_reg   <= drdy_p_next;
      drdy_t_reg   <= drdy_t_next;
      por_reg      <= por_next;
      act_reg      <= act_next;
    end
  end

  // Result registers show the filtered path
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      press_reg <= `SSFR_RST_DATA;
      temp_reg  <= `SSFR_RST_DATA;
    end else if (CE_I) begin
      if (PRESS_FILT_I.vld) press_reg <= PRESS_FILT_I.val;
      if (TEMP_FILT_I.vld) temp_reg <= TEMP_FILT_I.val;
    end
  end

  // Configuration registers
  ssfr_byte_t wtm0_reg;
  ssfr_byte_t wtm1_reg;
  ssfr_byte_t fc1_reg;
  ssfr_byte_t fc2_reg;
  ssfr_byte_t ic_reg;
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      wtm0_reg <= `SSFR_RST_WTM0;
      wtm1_reg <= `SSFR_RST_WTM1;
      fc1_reg  <= `SSFR_RST_FC1;
      fc2_reg  <= `SSFR_RST_FC2;
      ic_reg   <= `SSFR_RST_IC;
    end else if (CE_I && wr) begin
      if (idx == `SSFR_IX_WTM0) wtm0_reg <= PWDATA_I[7:0];
      if (idx == `SSFR_IX_WTM1) wtm1_reg <= PWDATA_I[7:0] & `SSFR_MSK_WTM1;
      if (idx == `SSFR_IX_FC1) fc1_reg <= PWDATA_I[7:0] & `SSFR_MSK_FC;
      if (idx == `SSFR_IX_FC2) fc2_reg <= PWDATA_I[7:0] & `SSFR_MSK_FC;
      if (idx == `SSFR_IX_IC) ic_reg <= PWDATA_I[7:0] & `SSFR_MSK_IC;
    end
  end
  wire [8:0] wtm = {wtm1_reg[0], wtm0_reg};

  // Queue input: source select and downsampling
  wire        fifo_on  = fc1_reg[`SSFR_FC1_MODE];
  wire        use_filt = fc2_reg[`SSFR_FC2_SEL_HI:`SSFR_FC2_SEL_LO] == `SSFR_SEL_FILT;
  ssfr_sample_t p_src;
  ssfr_sample_t t_src;
  assign p_src = use_filt ? PRESS_FILT_I : PRESS_RAW_I;
  assign t_src = use_filt ? TEMP_FILT_I : TEMP_RAW_I;
  wire [2:0]  sub     = fc2_reg[`SSFR_FC2_SUB_HI:`SSFR_FC2_SUB_LO];
  wire [6:0]  sub_msk = 7'((8'h01 << sub) - 8'h01);
  logic [6:0] sub_cnt_reg;
  wire        smp     = p_src.vld | t_src.vld;
  wire        keep    = (sub_cnt_reg & sub_msk) == 7'h00;
  wire        p_take  = fifo_on & smp & keep & p_src.vld & fc1_reg[`SSFR_FC1_PRESS];
  wire        t_take  = fifo_on & smp & keep & t_src.vld & fc1_reg[`SSFR_FC1_TEMP];

  // Byte serialiser; samples arriving mid-frame are dropped, a frame is six cycles at most
  logic [47:0] sbuf_reg;
  logic [2:0]  sleft_reg;
  wire         push = sleft_reg != 3'h0;
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      sub_cnt_reg <= 7'h00;
      sbuf_reg    <= 48'h0000_0000_0000;
      sleft_reg   <= 3'h0;
    end else if (CE_I) begin
      if (smp) sub_cnt_reg <= sub_cnt_reg + 7'h01;
      if (push) begin
        sbuf_reg  <= sbuf_reg >> 8;
        sleft_reg <= sleft_reg - 3'h1;
      end else if (p_take && t_take) begin
        sbuf_reg  <= {t_src.val, p_src.val};
        sleft_reg <= 3'h6;
      end else if (p_take || t_take) begin
        sbuf_reg  <= {24'h00_0000, p_take ? p_src.val : t_src.val};
        sleft_reg <= 3'h3;
      end
    end
  end

  // Queue storage
  ssfr_byte_t mem [0:511];
  logic [8:0] wp_reg;
  logic [8:0] rp_reg;
  logic [9:0] cnt_reg;
  logic [1:0] tix_reg;
  wire        full   = cnt_reg == `SSFR_FIFO_BYTES;
  wire        empty  = cnt_reg == 10'h000;
  wire        pop    = rd_fd & ~empty;
  wire        room   = ~full | pop;
  wire        stop   = fc1_reg[`SSFR_FC1_STOP];
  wire        wr_en  = push & (room | ~stop);
  wire        ovw    = push & ~room & ~stop;
  wire        rp_adv = pop | ovw;
  wire [9:0]  cnt_next = cnt_reg + {9'h000, wr_en} - {9'h000, rp_adv};
  wire        t_rd   = rd_fd & empty & fc1_reg[`SSFR_FC1_TIME];
  wire [7:0]  t_byte = (tix_reg == 2'h0) ? SENSOR_TIME_I[7:0] :
                       (tix_reg == 2'h1) ? SENSOR_TIME_I[15:8] : SENSOR_TIME_I[23:16];
  wire [7:0]  fd_byte = !empty ? mem[rp_reg] :
                        fc1_reg[`SSFR_FC1_TIME] ? t_byte : 8'h00;

  always_ff @(posedge CLK_SYS_I) begin
    if (CE_I && wr_en) mem[wp_reg] <= sbuf_reg[7:0];
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I || (CE_I && !fifo_on)) begin
      wp_reg  <= 9'h000;
      rp_reg  <= 9'h000;
      cnt_reg <= 10'h000;
      tix_reg <= 2'h0;
    end else if (CE_I) begin
      if (wr_en) wp_reg <= wp_reg + 9'h001;
      if (rp_adv) rp_reg <= rp_reg + 9'h001;
      cnt_reg <= cnt_next;
      if (push) tix_reg <= 2'h0;
      else if (t_rd) tix_reg <= (tix_reg == 2'h2) ? 2'h0 : tix_reg + 2'h1;
    end
  end

  // Interrupt sources: 0 watermark, 1 full, 2 data ready
  logic [2:0] irq_cond;
  logic [2:0] irq_flag_reg;
  logic [2:0] irq_flag_next;
  assign irq_cond[0] = ic_reg[`SSFR_IC_WTM] & (cnt_reg >= {1'b0, wtm});
  assign irq_cond[1] = ic_reg[`SSFR_IC_FULL] & full;
  assign irq_cond[2] = ic_reg[`SSFR_IC_DRDY] & (PRESS_FILT_I.vld | TEMP_FILT_I.vld);
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_irq
      assign irq_flag_next[gi] = ic_reg[`SSFR_IC_LATCH] ?
                                 (irq_flag_reg[gi] & ~rd_ist) | irq_cond[gi] : irq_cond[gi];
    end
  endgenerate
  // Pin follows flags one cycle late so it stays a flop output
  wire pin_next = ic_reg[`SSFR_IC_LEVEL] ? |irq_flag_reg : ~|irq_flag_reg;

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      irq_flag_reg <= 3'h0;
      INT_O        <= 1'b1;
      INT_OE_N_O   <= 1'b0;
      INT_STRONG_O <= 1'b0;
    end else if (CE_I) begin
      irq_flag_reg <= irq_flag_next;
      INT_O        <= pin_next;
      INT_OE_N_O   <= ic_reg[`SSFR_IC_OD] & pin_next;
      INT_STRONG_O <= ic_reg[`SSFR_IC_DS];
    end
  end

  // Read map
  ssfr_byte_t rmap [0:31];
  always_comb begin
    rmap = '{default: 8'h00};
    rmap[`SSFR_IX_ERR][`SSFR_ERR_FATAL] = fatal_reg;
    rmap[`SSFR_IX_ERR][`SSFR_ERR_CMD]   = cmd_err_reg;
    rmap[`SSFR_IX_ERR][`SSFR_ERR_CONF]  = conf_err_reg;
    rmap[`SSFR_IX_STAT][`SSFR_ST_RDY]    = cmd_rdy_reg;
    rmap[`SSFR_IX_STAT][`SSFR_ST_DRDY_P] = drdy_p_reg;
    rmap[`SSFR_IX_STAT][`SSFR_ST_DRDY_T] = drdy_t_reg;
    rmap[`SSFR_IX_P0]  = press_reg[7:0];
    rmap[`SSFR_IX_P1]  = press_reg[15:8];
    rmap[`SSFR_IX_P2]  = press_reg[23:16];
    rmap[`SSFR_IX_T0]  = temp_reg[7:0];
    rmap[`SSFR_IX_T1]  = temp_reg[15:8];
    rmap[`SSFR_IX_T2]  = temp_reg[23:16];
    rmap[`SSFR_IX_TS0] = SENSOR_TIME_I[7:0];
    rmap[`SSFR_IX_TS1] = SENSOR_TIME_I[15:8];
    rmap[`SSFR_IX_TS2] = SENSOR_TIME_I[23:16];
    rmap[`SSFR_IX_EVT][`SSFR_EV_POR] = por_reg;
    rmap[`SSFR_IX_EVT][`SSFR_EV_ACT] = act_reg;
    rmap[`SSFR_IX_IST][`SSFR_IS_WTM]  = irq_flag_reg[0];
    rmap[`SSFR_IX_IST][`SSFR_IS_FULL] = irq_flag_reg[1];
    rmap[`SSFR_IX_IST][`SSFR_IS_DRDY] = irq_flag_reg[2];
    rmap[`SSFR_IX_LEN0] = cnt_reg[7:0];
    rmap[`SSFR_IX_LEN1] = {6'h00, cnt_reg[9:8]};
    rmap[`SSFR_IX_FDATA] = fd_byte;
    rmap[`SSFR_IX_WTM0] = wtm0_reg;
    rmap[`SSFR_IX_WTM1] = wtm1_reg;
    rmap[`SSFR_IX_FC1]  = fc1_reg;
    rmap[`SSFR_IX_FC2]  = fc2_reg;
    rmap[`SSFR_IX_IC]   = ic_reg;
  end

  // Fixed zero-wait answer: data sampled at setup, side effects at completion
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      PRDATA_O  <= 32'h0000_0000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else if (CE_I) begin
      PREADY_O  <= setup;
      PSLVERR_O <= setup & ~hit;
      PRDATA_O  <= (setup && !PWRITE_I && hit) ? {24'h00_0000, rmap[idx]} : 32'h0000_0000;
    end
  end

  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);

  sequence setup_s;
    CE_I && PSEL_I && !PENABLE_I;
  endsequence
  sequence err_read_s;
    CE_I && rd_err && !CMD_FAIL_I;
  endsequence

  bus_ready_a: assert property (setup_s |=> PREADY_O)
    else $error("pready missing after setup");
  cmd_clear_a: assert property (err_read_s |=> !cmd_err_reg)
    else $error("command error not cleared on read");
  conf_gate_a: assert property (CE_I && !conf_err_reg && !(POWER_MODE_I == `SSFR_MODE_NORMAL) |=> !conf_err_reg)
    else $error("config error set outside normal mode");
  cmd_ready_a: assert property (CE_I ##1 CE_I |-> cmd_rdy_reg == !$past(CMD_BUSY_I))
    else $error("ready bit not inverse of busy");
  press_clr_a: assert property (CE_I && rd_pres && !PRESS_FILT_I.vld |=> !drdy_p_reg)
    else $error("pressure ready not cleared");
  por_clear_a: assert property (CE_I && rd_evt && !SOFT_RESET_I |=> !por_reg)
    else $error("power-up flag not cleared");
  fifo_pop_a: assert property (CE_I && fifo_on && pop && !wr_en |=> cnt_reg == $past(cnt_reg) - 10'h001)
    else $error("count not decremented on pop");
  stop_full_a: assert property (CE_I && fifo_on && full && stop && push && !pop |=> full && $stable(wp_reg))
    else $error("write while full and stopping");
  wtm_flag_a: assert property (CE_I && irq_cond[0] |=> irq_flag_reg[0])
    else $error("watermark flag missing");
  latch_hold_a: assert property (CE_I && ic_reg[`SSFR_IC_LATCH] && irq_flag_reg[1] && !rd_ist |=> irq_flag_reg[1])
    else $error("latched flag dropped");
  pin_level_a: assert property (CE_I && !ic_reg[`SSFR_IC_LEVEL] && |irq_flag_reg && !$changed(ic_reg) |=> !INT_O)
    else $error("active-low pin not low");
endmodule : ssfr_top

/* design/ssfr_cfg.svh */
`ifndef SSFR_CFG_SVH
`define SSFR_CFG_SVH
`define SSFR_IX_ERR      5'h02
`define SSFR_IX_STAT     5'h03
`define SSFR_IX_P0       5'h04
`define SSFR_IX_P1       5'h05
`define SSFR_IX_P2       5'h06
`define SSFR_IX_T0       5'h07
`define SSFR_IX_T1       5'h08
`define SSFR_IX_T2       5'h09
`define SSFR_IX_TS0      5'h0C
`define SSFR_IX_TS1      5'h0D
`define SSFR_IX_TS2      5'h0E
`define SSFR_IX_EVT      5'h10
`define SSFR_IX_IST      5'h11
`define SSFR_IX_LEN0     5'h12
`define SSFR_IX_LEN1     5'h13
`define SSFR_IX_FDATA    5'h14
`define SSFR_IX_WTM0     5'h15
`define SSFR_IX_WTM1     5'h16
`define SSFR_IX_FC1      5'h17
`define SSFR_IX_FC2      5'h18
`define SSFR_IX_IC       5'h19
`define SSFR_MAP_MASK    32'h03FF_73FC
`define SSFR_ERR_FATAL   0
`define SSFR_ERR_CMD     1
`define SSFR_ERR_CONF    2
`define SSFR_ST_RDY      4
`define SSFR_ST_DRDY_P   5
`define SSFR_ST_DRDY_T   6
`define SSFR_EV_POR      0
`define SSFR_EV_ACT      1
`define SSFR_IS_WTM      0
`define SSFR_IS_FULL     1
`define SSFR_IS_DRDY     3
`define SSFR_FC1_MODE    0
`define SSFR_FC1_STOP    1
`define SSFR_FC1_TIME    2
`define SSFR_FC1_PRESS   3
`define SSFR_FC1_TEMP    4
`define SSFR_FC2_SUB_LO  0
`define SSFR_FC2_SUB_HI  2
`define SSFR_FC2_SEL_LO  3
`define SSFR_FC2_SEL_HI  4
`define SSFR_SEL_FILT    2'h1
`define SSFR_IC_OD       0
`define SSFR_IC_LEVEL    1
`define SSFR_IC_LATCH    2
`define SSFR_IC_WTM      3
`define SSFR_IC_FULL     4
`define SSFR_IC_DS       5
`define SSFR_IC_DRDY     6
`define SSFR_MODE_NORMAL 2'h3
`define SSFR_RST_WTM0    8'h01
`define SSFR_RST_WTM1    8'h00
`define SSFR_RST_FC1     8'h02
`define SSFR_RST_FC2     8'h02
`define SSFR_RST_IC      8'h02
`define SSFR_MSK_WTM1    8'h01
`define SSFR_MSK_FC      8'h1F
`define SSFR_MSK_IC      8'h7F
`define SSFR_RST_DATA    24'h80_0000
`define SSFR_FIFO_BYTES  10'h200
`endif

/* design/ssfr_pkg.sv */
package ssfr_pkg;
  typedef struct packed {
    logic        vld;
    logic [23:0] val;
  } ssfr_sample_t;
  typedef logic [7:0] ssfr_byte_t;
endpackage : ssfr_pkg

/* tb/ssfr_host_model.sv */
`timescale 1ns/1ps
module ssfr_host_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0000_0000;
  end
  // Hung flags a slave that never answers
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output logic hung);
    int n;
    @(posedge clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= wd;
    @(posedge clk_i);
    penable_o <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_i !== 1'b1 && n < 16);
    hung = (pready_i !== 1'b1);
    rd = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // Inverted idle lines so a stale value never looks valid
    paddr_o <= ~a;
    pwdata_o <= ~wd;
  endtask : xfer
endmodule : ssfr_host_model

/* tb/ssfr_top_tb_top.sv */
`timescale 1ns/1ps
`include "ssfr_cfg.svh"
module ssfr_top_tb_top;
  import ssfr_pkg::*;
  logic         clk, rst_n, psel, pen, pwr, rdy, serr, ipin, ioe_n, istr;
  logic         busy, cfail, cfault, fatal, conv, srst, ce;
  logic [7:0]   padr;
  logic [31:0]  pwd, prd;
  logic [23:0]  stime;
  logic [1:0]   pmode;
  ssfr_sample_t pr, pf, tr, tf;
  int           num_errors, tests_run;
  logic [4:0]   rix [13] = '{`SSFR_IX_WTM0, `SSFR_IX_WTM1, `SSFR_IX_FC1, `SSFR_IX_FC2, `SSFR_IX_IC,
    `SSFR_IX_EVT, `SSFR_IX_P2, `SSFR_IX_T2, `SSFR_IX_ERR, `SSFR_IX_STAT, `SSFR_IX_LEN0, `SSFR_IX_P0, `SSFR_IX_T0};
  logic [7:0]   rexp [13] = '{8'h01, 8'h00, 8'h02, 8'h02, 8'h02, 8'h01, 8'h80, 8'h80, 8'h00, 8'h10, 8'h00,
    8'h00, 8'h00};
  logic [4:0]   wix [5] = '{`SSFR_IX_WTM0, `SSFR_IX_WTM1, `SSFR_IX_FC1, `SSFR_IX_FC2, `SSFR_IX_IC};
  logic [7:0]   wexp [5] = '{8'hA5, 8'h01, 8'h1F, 8'h1F, 8'h7F};
  logic [7:0]   qexp [5] = '{8'h22, 8'h11, 8'h66, 8'h55, 8'h44};

  ssfr_top i_ssfr_top (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(ce), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(serr),
    .PRESS_RAW_I(pr), .PRESS_FILT_I(pf), .TEMP_RAW_I(tr), .TEMP_FILT_I(tf), .SENSOR_TIME_I(stime),
    .POWER_MODE_I(pmode), .CMD_BUSY_I(busy), .CMD_FAIL_I(cfail), .CONF_FAULT_I(cfault),
    .FATAL_FAULT_I(fatal), .CONV_ACTIVE_I(conv), .SOFT_RESET_I(srst), .INT_O(ipin),
    .INT_OE_N_O(ioe_n), .INT_STRONG_O(istr));
  ssfr_host_model i_ssfr_host_model (.clk_i(clk), .prdata_i(prd), .pready_i(rdy), .pslverr_i(serr),
    .psel_o(psel), .penable_o(pen), .pwrite_o(pwr), .paddr_o(padr), .pwdata_o(pwd));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r,
                     output logic e);
    logic h;
    i_ssfr_host_model.xfer(w, a, {24'h00_0000, d}, r, e, h);
    if (h) begin
      num_errors++;
      $display("wrong value at %0t: no bus answer", $time);
      stop_test();
    end
  endtask : bus
  task automatic wr(input logic [4:0] ix, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    bus(1'b1, {1'b0, ix, 2'b00}, d, r, e);
  endtask : wr
  task automatic rd(input logic [4:0] ix, input logic [7:0] x);
    logic [31:0] r;
    logic        e;
    bus(1'b0, {1'b0, ix, 2'b00}, 8'h00, r, e);
    check(r, {24'h00_0000, x}, $sformatf("read index %h", ix));
    check(32'(e), 32'h0000_0000, "slave error");
  endtask : rd
  // Raw carries the inverse so a wrong source choice shows
  task automatic sample(input logic [3:0] v, input logic [23:0] pv, input logic [23:0] tv);
    @(posedge clk);
    pr <= '{v[0], ~pv};
    pf <= '{v[1], pv};
    tr <= '{v[2], ~tv};
    tf <= '{v[3], tv};
    @(posedge clk);
    pr.vld <= 1'b0;
    pf.vld <= 1'b0;
    tr.vld <= 1'b0;
    tf.vld <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : sample
  task automatic fill(input logic [7:0] n);
    for (int i = 1; i <= n; i++) sample(4'b1010, {16'h0000, 8'(i)}, {8'h00, 8'(i), 8'h00});
  endtask : fill
  task automatic pulse_err(input int k);
    @(posedge clk);
    if (k == 0) cfail <= 1'b1; else if (k == 1) cfault <= 1'b1; else srst <= 1'b1;
    @(posedge clk);
    cfail <= 1'b0;
    cfault <= 1'b0;
    srst <= 1'b0;
  endtask : pulse_err

  initial begin
    logic [31:0] r;
    logic        e;
    {rst_n, busy, cfail, cfault, fatal, conv, srst} = 7'h00;
    {pr, pf, tr, tf} = '0;
    stime = 24'h0A_0B0C;
    pmode = 2'h0;
    ce = 1'b1;
    num_errors = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 13; i++) rd(rix[i], rexp[i]);
    rd(`SSFR_IX_EVT, 8'h00);
    bus(1'b0, 8'h80, 8'h00, r, e);
    check(r, 32'h0000_0000, "unmapped data");
    check(32'(e), 32'h0000_0001, "unmapped error");
    bus(1'b0, 8'h28, 8'h00, r, e);
    check(r, 32'h0000_0000, "reserved data");
    check(32'(e), 32'h0000_0001, "reserved error");
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      wr(wix[i], 8'hFF);
      if (i == 0) wr(wix[i], 8'hA5);
      rd(wix[i], wexp[i]);
    end
    check(32'(istr), 32'h0000_0001, "strength");
    wr(`SSFR_IX_STAT, 8'hFF);
    rd(`SSFR_IX_STAT, 8'h10);
    wr(`SSFR_IX_IC, 8'h01);
    repeat (2) @(posedge clk);
    check(32'({ipin, ioe_n}), 32'h0000_0003, "open-drain idle");
    wr(`SSFR_IX_IC, 8'h02);
    $display("test config done");
    fatal <= 1'b1;
    rd(`SSFR_IX_ERR, 8'h01);
    rd(`SSFR_IX_ERR, 8'h01);
    fatal <= 1'b0;
    pulse_err(0);
    rd(`SSFR_IX_ERR, 8'h02);
    rd(`SSFR_IX_ERR, 8'h00);
    for (int m = 0; m < 4; m++) begin
      pmode <= 2'(m);
      pulse_err(1);
      rd(`SSFR_IX_ERR, (m == 3) ? 8'h04 : 8'h00);
      rd(`SSFR_IX_ERR, 8'h00);
    end
    busy <= 1'b1;
    rd(`SSFR_IX_STAT, 8'h00);
    busy <= 1'b0;
    $display("test errors done");
    sample(4'b1010, 24'h12_3456, 24'hAB_CDEF);
    rd(`SSFR_IX_STAT, 8'h70);
    rd(`SSFR_IX_P1, 8'h34);
    rd(`SSFR_IX_STAT, 8'h50);
    rd(`SSFR_IX_P0, 8'h56);
    rd(`SSFR_IX_P2, 8'h12);
    rd(`SSFR_IX_T2, 8'hAB);
    rd(`SSFR_IX_STAT, 8'h10);
    rd(`SSFR_IX_T0, 8'hEF);
    rd(`SSFR_IX_T1, 8'hCD);
    rd(`SSFR_IX_TS0, 8'h0C);
    rd(`SSFR_IX_TS1, 8'h0B);
    rd(`SSFR_IX_TS2, 8'h0A);
    rd(`SSFR_IX_IST, 8'h00);
    conv <= 1'b1;
    rd(`SSFR_IX_WTM0, 8'hA5);
    conv <= 1'b0;
    rd(`SSFR_IX_EVT, 8'h02);
    rd(`SSFR_IX_EVT, 8'h00);
    $display("test results done");
    wr(`SSFR_IX_FC2, 8'h08);
    wr(`SSFR_IX_FC1, 8'h19);
    wr(`SSFR_IX_WTM0, 8'h06);
    wr(`SSFR_IX_WTM1, 8'h00);
    wr(`SSFR_IX_IC, 8'h0C);
    sample(4'b1010, 24'h11_2233, 24'h44_5566);
    rd(`SSFR_IX_LEN0, 8'h06);
    rd(`SSFR_IX_LEN1, 8'h00);
    check(32'({ipin, ioe_n}), 32'h0000_0000, "pin low drive");
    rd(`SSFR_IX_FDATA, 8'h33);
    rd(`SSFR_IX_LEN0, 8'h05);
    repeat (3) @(posedge clk);
    check(32'(ipin), 32'h0000_0000, "latched pin");
    rd(`SSFR_IX_IST, 8'h01);
    repeat (3) @(posedge clk);
    check(32'(ipin), 32'h0000_0001, "pin released");
    rd(`SSFR_IX_IST, 8'h00);
    for (int i = 0; i < 5; i++) rd(`SSFR_IX_FDATA, qexp[i]);
    rd(`SSFR_IX_FDATA, 8'h00);
    wr(`SSFR_IX_FC1, 8'h1D);
    rd(`SSFR_IX_FDATA, 8'h0C);
    rd(`SSFR_IX_FDATA, 8'h0B);
    wr(`SSFR_IX_IC, 8'h0A);
    sample(4'b1010, 24'h11_2233, 24'h44_5566);
    // Pin settles two edges after the last byte lands
    repeat (2) @(posedge clk);
    check(32'(ipin), 32'h0000_0001, "level pin");
    wr(`SSFR_IX_FC1, 8'h00);
    sample(4'b1010, 24'h11_2233, 24'h44_5566);
    check(32'(ipin), 32'h0000_0000, "pin follows");
    rd(`SSFR_IX_LEN0, 8'h00);
    $display("test queue done");
    wr(`SSFR_IX_FC1, 8'h09);
    for (int s = 0; s < 4; s++) begin
      wr(`SSFR_IX_FC2, 8'(s << 3));
      sample(4'b0011, 24'h00_00A5, 24'h00_0000);
      rd(`SSFR_IX_FDATA, (s == 1) ? 8'hA5 : 8'h5A);
      wr(`SSFR_IX_FC1, 8'h00);
      wr(`SSFR_IX_FC1, 8'h09);
    end
    for (int k = 0; k < 3; k++) begin
      wr(`SSFR_IX_FC2, 8'h08 | 8'(k));
      repeat (4) sample(4'b0010, 24'h00_0001, 24'h00_0000);
      rd(`SSFR_IX_LEN0, 8'(3 * (4 >> k)));
      wr(`SSFR_IX_FC1, 8'h00);
      wr(`SSFR_IX_FC1, 8'h09);
    end
    $display("test source done");
    wr(`SSFR_IX_IC, 8'h10);
    wr(`SSFR_IX_FC2, 8'h08);
    wr(`SSFR_IX_FC1, 8'h1B);
    fill(8'd90);
    rd(`SSFR_IX_LEN0, 8'h00);
    rd(`SSFR_IX_LEN1, 8'h02);
    rd(`SSFR_IX_IST, 8'h02);
    rd(`SSFR_IX_FDATA, 8'h01);
    wr(`SSFR_IX_FC1, 8'h00);
    wr(`SSFR_IX_FC1, 8'h19);
    fill(8'd90);
    rd(`SSFR_IX_FDATA, 8'h05);
    $display("test full done");
    // Failure pulse while frozen must be lost
    ce <= 1'b0;
    pulse_err(0);
    ce <= 1'b1;
    rd(`SSFR_IX_ERR, 8'h00);
    pulse_err(2);
    repeat (2) @(posedge clk);
    rd(`SSFR_IX_EVT, 8'h01);
    $display("test soft reset done");
    stop_test();
  end
endmodule : ssfr_top_tb_top
